// [cam_mode_memory_block.sv]
`timescale 1ns/1ps
`default_nettype none

module cam_mode_memory_block
   import cam_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic wr_req,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [CAM_WIDTH-1:0] wr_value,
   input wire logic [CAM_WIDTH-1:0] wr_care,
   input wire logic srch_req,
   input wire logic [CAM_WIDTH-1:0] srch_key,
   input wire logic unencoded_sel,
   output logic busy,
   output logic result_valid,
   output logic [ADDR_W-1:0] result_addr,
   output logic match_found,
   output logic [HALF_W-1:0] match_lines,
   output logic lines_upper
);

   cam_state_t state;
   cam_state_t next_state;
   logic [ADDR_W-1:0] addr_q;
   logic [CAM_WIDTH-1:0] value_q;
   logic [CAM_WIDTH-1:0] care_q;
   logic srch_d;
   logic unenc_d;
   logic [CAM_WORDS-1:0] match_vec;
   logic [CAM_WORDS-1:0] match_hold;
   logic [ADDR_W-1:0] enc_addr;
   logic unenc_out;

   // Requests are only taken when idle; a write wins over a search.
   wire logic idle = (state == ST_IDLE);
   wire logic wr_take = idle && wr_req;
   wire logic srch_take = idle && !wr_req && srch_req;
   wire logic has_dontcare = (care_q != CARE_ALL);
   wire logic val_we = (state == ST_WR_VAL);
   wire logic care_we = (state == ST_WR_MASK);
   wire logic any_match = |match_vec;

   // Sequencer for writes and for the second unencoded beat.
   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE:
         begin
            if (wr_take)
               next_state = ST_WR_VAL;
            else if (srch_d && unenc_d)
               next_state = ST_UNENC_HI;
         end
         ST_WR_VAL: next_state = has_dontcare ? ST_WR_MASK : ST_IDLE;
         ST_WR_MASK: next_state = ST_IDLE;
         ST_UNENC_HI: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   // Lowest-index priority; with duplicates the address is only one of them.
   always_comb
   begin
      enc_addr = ADDR_RST;
      for (int k = CAM_WORDS - 1; k >= 0; k--)
      begin
         if (match_vec[k])
            enc_addr = ADDR_W'(k);
      end
   end

   cam_store i_cam_store (
      .clock(clock),
      .sys_rst(sys_rst),
      .val_we(val_we),
      .care_we(care_we),
      .wr_addr(addr_q),
      .wr_value(value_q),
      .wr_care(care_q),
      .search_key(srch_key),
      .match_vec(match_vec)
   );

   // Write operands are latched once, so the storage sees them steadily.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         state <= ST_IDLE;
         busy <= 1'b0;
         addr_q <= ADDR_RST;
         value_q <= CARE_NONE;
         care_q <= CARE_ALL;
         srch_d <= 1'b0;
         unenc_d <= 1'b0;
      end
      else
      begin
         state <= next_state;
         busy <= (next_state != ST_IDLE) || srch_take;
         if (wr_take)
         begin
            addr_q <= wr_addr;
            value_q <= wr_value;
            care_q <= wr_care;
         end
         srch_d <= srch_take;
         unenc_d <= srch_take && unencoded_sel;
      end
   end

   // Result outputs: encoded in one beat, unencoded low half then high half.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         result_valid <= 1'b0;
         result_addr <= ADDR_RST;
         match_found <= 1'b0;
         match_lines <= LINES_RST;
         lines_upper <= 1'b0;
         match_hold <= MATCH_RST;
         unenc_out <= 1'b0;
      end
      else
      begin
         result_valid <= srch_d || (state == ST_UNENC_HI);
         lines_upper <= (state == ST_UNENC_HI);
         if (srch_d)
         begin
            match_hold <= match_vec;
            unenc_out <= unenc_d;
            result_addr <= unenc_d ? ADDR_RST : enc_addr;
            match_found <= any_match;
            match_lines <= unenc_d ? match_vec[HALF_W-1:0] : LINES_RST;
         end
         else if (state == ST_UNENC_HI)
         begin
            match_lines <= match_hold[CAM_WORDS-1:HALF_W];
         end
      end
   end

   // All checks share the one user clock and sleep through reset.
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   chk_write_two_cycles: assert property (
      wr_take && (wr_care == CARE_ALL) |=> val_we ##1 idle)
      else $error("Plain write did not finish in two cycles.");
   chk_write_third_cycle: assert property (
      wr_take && (wr_care != CARE_ALL) |=> val_we ##1 care_we ##1 idle)
      else $error("Don't-care write did not take three cycles.");
   chk_no_search_busy: assert property (
      !idle |=> !srch_d)
      else $error("Search taken while the block was busy.");
   chk_unenc_two_beats: assert property (
      srch_take && unencoded_sel |=> ##1 result_valid && !lines_upper ##1 result_valid && lines_upper)
      else $error("Unencoded result not shown over two beats.");
   chk_encoded_one_beat: assert property (
      srch_take && !unencoded_sel |=> ##1 result_valid && !lines_upper ##1 !result_valid)
      else $error("Encoded result not a single beat.");
   chk_found_flag: assert property (
      srch_d |=> match_found == $past(any_match))
      else $error("Match-found flag disagrees with compare.");
   chk_enc_addr_hits: assert property (
      result_valid && !unenc_out && match_found |-> match_hold[result_addr])
      else $error("Encoded address does not point at a matching word.");
   chk_lines_all_matches: assert property (
      result_valid && unenc_out && lines_upper
         |-> match_lines == $past(match_vec[CAM_WORDS-1:HALF_W], 2))
      else $error("Upper match lines differ from compare result.");

   // The beats are held against the raw compare, not the hold register that feeds the upper beat.
   chk_lines_low_half: assert property (
      result_valid && unenc_out && !lines_upper |-> match_lines == $past(match_vec[HALF_W-1:0]))
      else $error("Lower match lines differ from compare result.");
   chk_busy_covers: assert property (
      (!idle || srch_d) |-> busy)
      else $error("Busy low while an operation is in progress.");
   chk_no_match_addr: assert property (
      result_valid && !unenc_out && !match_found |-> result_addr == ADDR_RST)
      else $error("Encoded address not zero when nothing matched.");
   chk_enc_lines_quiet: assert property (
      result_valid && !unenc_out |-> (match_lines == LINES_RST) && !lines_upper)
      else $error("Match lines active in an encoded beat.");
   chk_unenc_addr_zero: assert property (
      result_valid && unenc_out |-> result_addr == ADDR_RST)
      else $error("Encoded address shown in an unencoded beat.");
   chk_enc_lowest_hit: assert property (
      result_valid && !unenc_out && match_found
         |-> (match_hold & ((32'h00000001 << result_addr) - 32'h00000001)) == MATCH_RST)
      else $error("Encoded address is not the lowest matching word.");
   chk_search_frees: assert property (
      srch_take && !unencoded_sel |=> busy ##1 !busy)
      else $error("Encoded search did not release busy after one cycle.");

   // Covers show that each main scenario was really reached.
   cov_plain_write: cover property (wr_take ##1 val_we ##1 idle);
   cov_mask_write: cover property (wr_take ##1 val_we ##1 care_we);
   cov_encoded_hit: cover property (result_valid && !unenc_out && match_found);
   cov_no_match: cover property (result_valid && !unenc_out && !match_found);
   cov_unenc_multi: cover property (result_valid && unenc_out && ($countones(match_hold) > 1));

endmodule : cam_mode_memory_block

`default_nettype wire

// [cam_pkg.sv]
package cam_pkg;

   // Array shape of the content-addressable block.
   localparam int CAM_WORDS = 32;
   localparam int CAM_WIDTH = 32;
   localparam int ADDR_W = 5;
   localparam int HALF_W = 16;
   localparam int CAM_BITS = CAM_WORDS * CAM_WIDTH;

   // A set care bit compares; a clear care bit is a don't-care.
   localparam logic [CAM_WIDTH-1:0] CARE_ALL = 32'hFFFFFFFF;
   localparam logic [CAM_WIDTH-1:0] CARE_NONE = 32'h00000000;

   // Reset values of the result outputs and of the match vectors.
   localparam logic [ADDR_W-1:0] ADDR_RST = 5'h00;
   localparam logic [HALF_W-1:0] LINES_RST = 16'h0000;
   localparam logic [CAM_WORDS-1:0] MATCH_RST = 32'h00000000;

   // Default preload contents: all words zero and fully compared.
   localparam logic [CAM_BITS-1:0] PRELOAD_VALUE = {CAM_WORDS{CARE_NONE}};
   localparam logic [CAM_BITS-1:0] PRELOAD_CARE = {CAM_WORDS{CARE_ALL}};

   // Sequencer states, Gray coded along idle, value, mask.
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'h0,
      ST_WR_VAL = 2'h1,
      ST_WR_MASK = 2'h3,
      ST_UNENC_HI = 2'h2
   } cam_state_t;

endpackage : cam_pkg

// [cam_store.sv]
`timescale 1ns/1ps
`default_nettype none

module cam_store
   import cam_pkg::*;
#(
   parameter logic [CAM_BITS-1:0] INIT_VALUE = PRELOAD_VALUE,
   parameter logic [CAM_BITS-1:0] INIT_CARE = PRELOAD_CARE
)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic val_we,
   input wire logic care_we,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [CAM_WIDTH-1:0] wr_value,
   input wire logic [CAM_WIDTH-1:0] wr_care,
   input wire logic [CAM_WIDTH-1:0] search_key,
   output logic [CAM_WORDS-1:0] match_vec
);

   logic [CAM_WIDTH-1:0] data_mem [CAM_WORDS];
   logic [CAM_WIDTH-1:0] care_mem [CAM_WORDS];
   logic [CAM_WORDS-1:0] hit_vec;

   // One entry per iteration: storage, preload and its comparator.
   generate
      for (genvar i = 0; i < CAM_WORDS; i++)
      begin : g_entry
         wire logic sel = (wr_addr == ADDR_W'(i));
         // Only care bits take part, so a don't-care never blocks a match.
         assign hit_vec[i] = ((data_mem[i] ^ search_key) & care_mem[i]) == CARE_NONE;

         // Reset stands in for configuration and loads the preload image.
         always_ff @(posedge clock)
         begin
            if (sys_rst)
            begin
               data_mem[i] <= INIT_VALUE[i*CAM_WIDTH +: CAM_WIDTH];
               care_mem[i] <= INIT_CARE[i*CAM_WIDTH +: CAM_WIDTH];
            end
            else if (val_we && sel)
            begin
               data_mem[i] <= wr_value;
               care_mem[i] <= CARE_ALL;
            end
            else if (care_we && sel)
            begin
               care_mem[i] <= wr_care;
            end
         end
      end
   endgenerate

   // The match vector is registered so the result path starts from a flop.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         match_vec <= MATCH_RST;
      else
         match_vec <= hit_vec;
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   chk_value_stored: assert property (val_we |=> data_mem[$past(wr_addr)] == $past(wr_value))
      else $error("Written value not stored.");
   chk_mask_stored: assert property (care_we |=> care_mem[$past(wr_addr)] == $past(wr_care))
      else $error("Written care mask not stored.");
   chk_dontcare_entry: assert property ((care_mem[0] == CARE_NONE) && !val_we |=> match_vec[0])
      else $error("All don't-care word failed to match.");

endmodule : cam_store

`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench
   import cam_pkg::*;
;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic wr_req, srch_req, unencoded_sel, busy, result_valid, match_found, lines_upper;
   logic [ADDR_W-1:0] wr_addr, result_addr;
   logic [CAM_WIDTH-1:0] wr_value, wr_care, srch_key;
   logic [HALF_W-1:0] match_lines;
   logic [CAM_WIDTH-1:0] mem_val [CAM_WORDS];
   logic [CAM_WIDTH-1:0] mem_care [CAM_WORDS];
   logic [22:0] expq [$];
   int mismatches = 0;
   int cmp_count = 0;
   int n;
   // The four result fields as one word, in the order the notes are kept.
   wire logic [22:0] seen_beat = {lines_upper, match_found, result_addr, match_lines};

   // A 50 ns period.
   always #25 clock = ~clock;

   cam_mode_memory_block i_cam_mode_memory_block (.clock(clock), .sys_rst(sys_rst),
      .wr_req(wr_req), .wr_addr(wr_addr), .wr_value(wr_value), .wr_care(wr_care),
      .srch_req(srch_req), .srch_key(srch_key), .unencoded_sel(unencoded_sel), .busy(busy),
      .result_valid(result_valid), .result_addr(result_addr), .match_found(match_found),
      .match_lines(match_lines), .lines_upper(lines_upper));

   user_logic_model i_user_logic_model (.clock(clock), .busy(busy), .wr_req(wr_req),
      .wr_addr(wr_addr), .wr_value(wr_value), .wr_care(wr_care), .srch_req(srch_req),
      .srch_key(srch_key), .unencoded_sel(unencoded_sel));

   // Our own view of which words a key hits, built from what we wrote.
   function automatic logic [31:0] hits(logic [31:0] k);
      for (int i = 0; i < CAM_WORDS; i++)
         hits[i] = ((k ^ mem_val[i]) & mem_care[i]) == 32'h00000000;
   endfunction : hits

   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      cmp_count++;
      if (exp !== got)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic wrap_up();
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up

   // The bench's copy of the preload image, taken from the package constants.
   task automatic preload();
      for (int i = 0; i < CAM_WORDS; i++)
      begin
         mem_val[i] = PRELOAD_VALUE[i*32 +: 32];
         mem_care[i] = PRELOAD_CARE[i*32 +: 32];
      end
   endtask : preload

   // Notes the expected beats, lowest matching word as the address, then searches.
   task automatic find(logic [31:0] k, logic u);
      logic [31:0] m;
      logic [4:0] a;
      m = hits(k);
      a = 5'h00;
      for (int i = CAM_WORDS - 1; i >= 0; i--)
         if (m[i])
            a = i[4:0];
      if (u)
      begin
         expq.push_back({1'b0, |m, 5'h00, m[15:0]});
         expq.push_back({1'b1, |m, 5'h00, m[31:16]});
      end
      else
         expq.push_back({1'b0, |m, a, 16'h0000});
      i_user_logic_model.search(k, u, n);
   endtask : find

   task automatic put(int a, logic [31:0] v, logic [31:0] c);
      mem_val[a] = v;
      mem_care[a] = c;
      i_user_logic_model.write(a[4:0], v, c, n);
      check("write busy cycles", (c === CARE_ALL) ? 1 : 2, n);
   endtask : put

   // Result beats are read at the falling edge, well clear of the updates.
   always @(negedge clock)
      if (result_valid === 1'b1)
      begin
         if (expq.size() == 0)
            check("unexpected beat", 0, 1);
         else
            check("result", expq.pop_front(), seen_beat);
      end

   // Roughly eighteen times the expected run length.
   initial
   begin
      #(50 * 5000);
      mismatches++;
      wrap_up();
   end

   initial
   begin
      void'($urandom(32'h92407FA9));
      preload();
      repeat (12) @(posedge clock);
      sys_rst <= 1'b0;
      find(32'h00000000, 1'b1);
      find(32'h00000001, 1'b0);
      // Every fourth word gets a band of don't-care bits; never all ones, so three cycles.
      for (int i = 0; i < CAM_WORDS; i++)
         put(i, $urandom(), (i % 4 == 3) ? ~(32'h000000FF << (i % 24)) : CARE_ALL);
      // Keys flip every don't-care bit; words are distinct, so encoded stays valid.
      for (int i = 0; i < CAM_WORDS; i++)
         find(mem_val[i] ^ ~mem_care[i], i[0]);
      put(3, 32'hC0DE5A5A, CARE_ALL);
      put(20, 32'hC0DE5A5A, CARE_ALL);
      find(32'hC0DE5A5A, 1'b1);
      // A word that is all don't-care matches any key, so only unencoded is safe here.
      put(0, $urandom(), CARE_NONE);
      find($urandom(), 1'b1);
      // A second reset in mid-run must bring back the preload image.
      repeat (2) @(posedge clock);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      preload();
      find(32'h00000000, 1'b1);
      repeat (4) @(posedge clock);
      check("pending beats", 0, expq.size());
      wrap_up();
   end
endmodule : testbench
`default_nettype wire

// [user_logic_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Behaves as the user logic beside the block; it issues one request at a time.
module user_logic_model
   import cam_pkg::*;
(
   input wire logic clock,
   input wire logic busy,
   output var logic wr_req,
   output var logic [ADDR_W-1:0] wr_addr,
   output var logic [CAM_WIDTH-1:0] wr_value,
   output var logic [CAM_WIDTH-1:0] wr_care,
   output var logic srch_req,
   output var logic [CAM_WIDTH-1:0] srch_key,
   output var logic unencoded_sel
);
   // All requests start inactive so nothing is taken during reset.
   initial
   begin
      {wr_req, wr_addr, wr_value, wr_care, srch_req, srch_key, unencoded_sel} = '0;
   end

   // Called just after the take edge, when busy has just risen, so each edge until it
   // reads low counts one busy cycle; the bound keeps a stuck block from hanging us.
   task automatic wait_idle(output int n);
      n = 0;
      do
      begin
         @(posedge clock);
         #1;
         n++;
      end while (busy === 1'b1 && n < 8);
   endtask : wait_idle

   // The block latches operands at the take edge, so one cycle of request is enough.
   task automatic write(input logic [ADDR_W-1:0] a, input logic [CAM_WIDTH-1:0] v,
                        input logic [CAM_WIDTH-1:0] c, output int n);
      @(posedge clock);
      wr_req <= 1'b1;
      wr_addr <= a;
      wr_value <= v;
      wr_care <= c;
      @(posedge clock);
      wr_req <= 1'b0;
      wait_idle(n);
   endtask : write

   // A search is never issued until the previous operation has let busy fall.
   task automatic search(input logic [CAM_WIDTH-1:0] k, input logic u, output int n);
      @(posedge clock);
      srch_req <= 1'b1;
      srch_key <= k;
      unencoded_sel <= u;
      @(posedge clock);
      srch_req <= 1'b0;
      wait_idle(n);
   endtask : search
endmodule : user_logic_model
`default_nettype wire
